/* shared/energy_pkg.sv */
package energy_pkg;

	// ****************************************
	// Widths and register map
	// ****************************************
	localparam int SAMPLE_W = 24;
	localparam int VEXT_W = SAMPLE_W + 2;
	localparam int PROD_W = 2 * SAMPLE_W + 3;
	localparam int REG_ADDR_W = 4;

	localparam logic [REG_ADDR_W-1:0] CONFIG_OFS = 4'h0;
	localparam logic [REG_ADDR_W-1:0] STATUS_OFS = 4'h4;
	localparam logic [REG_ADDR_W-1:0] MASK_OFS = 4'h8;

	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [31:0] STATUS_RESET = 32'h00000000;
	localparam logic [31:0] MASK_RESET = 32'h00000000;
	// Only the six reverse-power flags exist
	localparam logic [31:0] STATUS_IMPL = 32'h00001DC0;

	localparam int REACT_MODE_LSB = 2;
	localparam int WIRING_LSB = 4;
	localparam int REV_ACT_SEL_BIT = 6;
	localparam int REV_REACT_SEL_BIT = 7;
	localparam int REV_ACT_BIT0 = 6;
	localparam int REV_REACT_BIT0 = 10;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef logic signed [SAMPLE_W-1:0] sample_t;
	typedef logic [SAMPLE_W-1:0] urms_t;
	typedef logic signed [VEXT_W-1:0] vext_t;
	typedef logic signed [PROD_W-1:0] prod_t;

	typedef enum logic [1:0] {
		REACT_SIGNED = 2'h0,
		REACT_RSV1 = 2'h1,
		REACT_FOLLOW_ACTIVE = 2'h2,
		REACT_RSV3 = 2'h3
	} react_mode_e;

	typedef enum logic [1:0] {
		WIRE_4W_3V = 2'h0,
		WIRE_3W_DELTA = 2'h1,
		WIRE_4W_2V = 2'h2,
		WIRE_4W_DELTA = 2'h3
	} wiring_e;

	typedef struct packed {
		sample_t v;
		sample_t i;
		sample_t i_shift;
		sample_t v_fund;
		sample_t i_fund;
		sample_t i_fund_shift;
		urms_t v_rms;
		urms_t i_rms;
	} phase_in_s;

	typedef struct packed {
		prod_t active;
		prod_t fund_active;
		prod_t reactive;
		prod_t fund_reactive;
		prod_t apparent;
	} addend_s;

	// ****************************************
	// Arithmetic helpers
	// ****************************************
	function automatic vext_t ext_v(sample_t v);
		return vext_t'(v);
	endfunction

	function automatic vext_t route_b_voltage(wiring_e cfg, sample_t va, sample_t vb, sample_t vc);
		vext_t r;
		unique case (cfg)
			WIRE_4W_2V: r = vext_t'(-ext_v(va) - ext_v(vc));
			WIRE_4W_DELTA: r = vext_t'(-ext_v(va));
			WIRE_4W_3V, WIRE_3W_DELTA: r = ext_v(vb);
		endcase
		return r;
	endfunction

	function automatic prod_t mul_vi(vext_t v, sample_t i);
		prod_t pv;
		prod_t pi;
		pv = prod_t'(v);
		pi = prod_t'(i);
		return pv * pi;
	endfunction

	function automatic prod_t mul_rms(urms_t v, urms_t i);
		logic [2*SAMPLE_W-1:0] p;
		p = {{SAMPLE_W{1'b0}}, v} * {{SAMPLE_W{1'b0}}, i};
		return prod_t'(p);
	endfunction

	function automatic logic [31:0] strb_to_mask(logic [3:0] s);
		logic [31:0] m;
		for (int k = 0; k < 4; k++) begin
			m[8*k +: 8] = {8{s[k]}};
		end
		return m;
	endfunction

endpackage

/* logic/phase_product.sv */
`timescale 1ns/10ps
module phase_product import energy_pkg::*; (
	input phase_in_s pin,
	input vext_t v_tot,
	input vext_t v_fund,
	input logic zero_all,
	input logic zero_app,
	input react_mode_e mode,
	output addend_s add,
	output prod_t react_raw,
	output prod_t fund_react_raw
);

	prod_t act;
	prod_t fact;
	logic follow;

	always_comb begin
		act = mul_vi(v_tot, pin.i);
		fact = mul_vi(v_fund, pin.i_fund);
		// Shifted current feeds the reactive products
		react_raw = mul_vi(v_tot, pin.i_shift);
		fund_react_raw = mul_vi(v_fund, pin.i_fund_shift);
		// Reserved codes fall back to signed accumulation
		follow = (mode == REACT_FOLLOW_ACTIVE);
		add.active = act;
		add.fund_active = fact;
		add.reactive = (follow && act < 0) ? prod_t'(-react_raw) : react_raw;
		add.fund_reactive = (follow && fact < 0) ? prod_t'(-fund_react_raw) : fund_react_raw;
		add.apparent = mul_rms(pin.v_rms, pin.i_rms);
		if (zero_all) begin
			add.active = '0;
			add.fund_active = '0;
			add.reactive = '0;
			add.fund_reactive = '0;
		end
		if (zero_app) begin
			add.apparent = '0;
		end
	end

endmodule

/* logic/rev_sign_detect.sv */
`timescale 1ns/10ps
module rev_sign_detect import energy_pkg::*; (
	input logic aclk,
	input logic aresetn,
	input logic ce,
	input logic sample_valid,
	input prod_t total,
	input prod_t fund,
	input logic use_fund,
	output logic flip
);

	logic neg_r;
	logic neg_nxt;
	logic neg_now;

	// Starts as positive, so a first negative sample flags
	always_comb begin
		neg_now = use_fund ? (fund < 0) : (total < 0);
		neg_nxt = sample_valid ? neg_now : neg_r;
		flip = sample_valid && (neg_now != neg_r);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			neg_r <= 1'b0;
		end else if (ce) begin
			neg_r <= neg_nxt;
		end
	end

endmodule

/* logic/energy_accum_input_select.sv */
// Functional notes
// - Reactive mode 00 accumulates total and fundamental reactive power with its sign.
// - Reactive mode codes 01 and 11 behave exactly like code 00.
// - Reactive mode 10 negates reactive power while the matching active power is negative.
// - The wiring field at config bits 5:4 chooses the products fed to the phase B accumulator.
// - Reactive products use the current shifted by minus ninety degrees.
// - Wiring 00 four-wire three sensors, 01 three-wire delta, 10 four-wire two sensors, 11 four-wire delta.
// - Phase A always uses its own voltage and current, shifted current for reactive.
// - Phase C always uses its own voltage and current, shifted current for reactive.
// - Phase B uses measured voltage under 00 and all its inputs are zero under 01.
// - Phase B voltage is minus A minus C under 10 and minus A under 11.
// - Config bit 6 picks total or fundamental active power for reverse flags at status bits 6 to 8.
// - Config bit 7 picks total or fundamental reactive power for reverse flags at status bits 10 to 12.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module energy_accum_input_select import energy_pkg::*; (
	input logic aclk,
	input logic aresetn,
	input logic ce,
	input logic sample_valid,
	input phase_in_s phase_a_in,
	input phase_in_s phase_b_in,
	input phase_in_s phase_c_in,
	output addend_s phase_a_accum_in,
	output addend_s phase_b_accum_in,
	output addend_s phase_c_accum_in,
	output logic accum_valid,
	output logic irq,
	input logic awvalid,
	output logic awready,
	input logic [REG_ADDR_W-1:0] awaddr,
	input logic wvalid,
	output logic wready,
	input logic [31:0] wdata,
	input logic [3:0] wstrb,
	output logic bvalid,
	input logic bready,
	output logic [1:0] bresp,
	input logic arvalid,
	output logic arready,
	input logic [REG_ADDR_W-1:0] araddr,
	output logic rvalid,
	input logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);

	// ****************************************
	// Configuration fields
	// ****************************************
	logic [7:0] cfg_r;
	logic [7:0] cfg_nxt;
	react_mode_e reactive_accum_mode;
	wiring_e wiring_config_select;
	logic rev_active_source_sel;
	logic rev_reactive_source_sel;

	assign reactive_accum_mode = react_mode_e'(cfg_r[REACT_MODE_LSB +: 2]);
	assign wiring_config_select = wiring_e'(cfg_r[WIRING_LSB +: 2]);
	assign rev_active_source_sel = cfg_r[REV_ACT_SEL_BIT];
	assign rev_reactive_source_sel = cfg_r[REV_REACT_SEL_BIT];

	// ****************************************
	// Input routing per phase
	// ****************************************
	phase_in_s pin [3];
	vext_t vt [3];
	vext_t vf [3];
	logic zall [3];
	logic zapp [3];
	addend_s add [3];
	prod_t rr [3];
	prod_t rfr [3];
	logic ev_act [3];
	logic ev_react [3];
	logic b_delta;

	assign b_delta = (wiring_config_select == WIRE_3W_DELTA);
	assign pin[0] = phase_a_in;
	assign pin[1] = phase_b_in;
	assign pin[2] = phase_c_in;
	assign vt[0] = ext_v(phase_a_in.v);
	assign vf[0] = ext_v(phase_a_in.v_fund);
	// Derived voltage only matters for the 4-wire codes
	assign vt[1] = route_b_voltage(wiring_config_select, phase_a_in.v, phase_b_in.v, phase_c_in.v);
	assign vf[1] = route_b_voltage(wiring_config_select, phase_a_in.v_fund, phase_b_in.v_fund, phase_c_in.v_fund);
	assign vt[2] = ext_v(phase_c_in.v);
	assign vf[2] = ext_v(phase_c_in.v_fund);
	assign zall[0] = 1'b0;
	assign zall[1] = b_delta;
	assign zall[2] = 1'b0;
	assign zapp[0] = 1'b0;
	assign zapp[1] = b_delta;
	assign zapp[2] = 1'b0;

	for (genvar p = 0; p < 3; p++) begin : g_phase
		phase_product u_prod (
			.pin(pin[p]),
			.v_tot(vt[p]),
			.v_fund(vf[p]),
			.zero_all(zall[p]),
			.zero_app(zapp[p]),
			.mode(reactive_accum_mode),
			.add(add[p]),
			.react_raw(rr[p]),
			.fund_react_raw(rfr[p])
		);
		// Phase B under delta sees zero power, so it flags at most once, on the first sample after a negative one
		rev_sign_detect u_rev_act (
			.aclk(aclk),
			.aresetn(aresetn),
			.ce(ce),
			.sample_valid(sample_valid),
			.total(add[p].active),
			.fund(add[p].fund_active),
			.use_fund(rev_active_source_sel),
			.flip(ev_act[p])
		);
		rev_sign_detect u_rev_react (
			.aclk(aclk),
			.aresetn(aresetn),
			.ce(ce),
			.sample_valid(sample_valid),
			.total(zall[p] ? prod_t'(0) : rr[p]),
			.fund(zall[p] ? prod_t'(0) : rfr[p]),
			.use_fund(rev_reactive_source_sel),
			.flip(ev_react[p])
		);
	end

	// ****************************************
	// Accumulator input registers
	// ****************************************
	addend_s a_r;
	addend_s b_r;
	addend_s c_r;
	addend_s a_nxt;
	addend_s b_nxt;
	addend_s c_nxt;
	logic valid_r;
	logic valid_nxt;

	always_comb begin
		a_nxt = a_r;
		b_nxt = b_r;
		c_nxt = c_r;
		valid_nxt = sample_valid;
		if (sample_valid) begin
			a_nxt = add[0];
			b_nxt = add[1];
			c_nxt = add[2];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_r <= '0;
			b_r <= '0;
			c_r <= '0;
			valid_r <= 1'b0;
		end else if (ce) begin
			a_r <= a_nxt;
			b_r <= b_nxt;
			c_r <= c_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign phase_a_accum_in = a_r;
	assign phase_b_accum_in = b_r;
	assign phase_c_accum_in = c_r;
	assign accum_valid = valid_r;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic aw_held_r, aw_held_nxt;
	logic w_held_r, w_held_nxt;
	logic [REG_ADDR_W-1:0] waddr_r, waddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic awready_r, awready_nxt;
	logic wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic arready_r, arready_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic do_write;
	logic [REG_ADDR_W-1:0] wword;
	logic [REG_ADDR_W-1:0] rword;
	logic [31:0] bmask;
	logic [31:0] status_r, status_nxt;
	logic [31:0] mask_r, mask_nxt;
	logic [31:0] ev_set;
	logic irq_r, irq_nxt;

	// Sub-word address bits are ignored, accesses select the whole word and writes change only the bytes set in wstrb
	assign wword = {waddr_r[REG_ADDR_W-1:2], 2'h0};
	assign rword = {araddr[REG_ADDR_W-1:2], 2'h0};

	// Handshakes only count while ce is high; ce must stay high during bus traffic
	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		do_write = aw_held_r && w_held_r && !bvalid_r;
		if (awvalid && awready_r) begin
			aw_held_nxt = 1'b1;
			waddr_nxt = awaddr;
		end
		if (wvalid && wready_r) begin
			w_held_nxt = 1'b1;
			wdata_nxt = wdata;
			wstrb_nxt = wstrb;
		end
		if (do_write) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (wword == CONFIG_OFS || wword == STATUS_OFS || wword == MASK_OFS) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
		awready_nxt = !aw_held_nxt && !bvalid_nxt;
		wready_nxt = !w_held_nxt && !bvalid_nxt;
		if (arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			unique case (rword)
				CONFIG_OFS: rdata_nxt = {24'h000000, cfg_r};
				STATUS_OFS: rdata_nxt = status_r;
				MASK_OFS: rdata_nxt = mask_r;
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
		arready_nxt = !rvalid_nxt;
	end

	// ****************************************
	// Registers, status and interrupt
	// ****************************************
	always_comb begin
		bmask = strb_to_mask(wstrb_r);
		cfg_nxt = cfg_r;
		mask_nxt = mask_r;
		status_nxt = status_r;
		ev_set = 32'h00000000;
		for (int p = 0; p < 3; p++) begin
			ev_set[REV_ACT_BIT0 + p] = ev_act[p];
			ev_set[REV_REACT_BIT0 + p] = ev_react[p];
		end
		if (do_write && wword == CONFIG_OFS && wstrb_r[0]) begin
			cfg_nxt = wdata_r[7:0];
		end
		if (do_write && wword == MASK_OFS) begin
			mask_nxt = ((mask_r & ~bmask) | (wdata_r & bmask)) & STATUS_IMPL;
		end
		if (do_write && wword == STATUS_OFS) begin
			status_nxt = status_r & ~(wdata_r & bmask);
		end
		// A new event outranks a same-cycle clear
		status_nxt = (status_nxt | ev_set) & STATUS_IMPL;
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= '0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
			cfg_r <= CONFIG_RESET;
			mask_r <= MASK_RESET;
			status_r <= STATUS_RESET;
			irq_r <= 1'b0;
		end else if (ce) begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			cfg_r <= cfg_nxt;
			mask_r <= mask_nxt;
			status_r <= status_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign irq = irq_r;

	// ****************************************
	// Assertions
	// ****************************************
	prod_t chk_a_act;
	prod_t chk_a_react;
	prod_t chk_c_act;
	prod_t chk_b_act2;
	prod_t chk_b_app;
	logic cfg_wr;

	assign chk_a_act = mul_vi(ext_v(phase_a_in.v), phase_a_in.i);
	assign chk_a_react = mul_vi(ext_v(phase_a_in.v), phase_a_in.i_shift);
	assign chk_c_act = mul_vi(ext_v(phase_c_in.v), phase_c_in.i);
	assign chk_b_act2 = mul_vi(vext_t'(-ext_v(phase_a_in.v) - ext_v(phase_c_in.v)), phase_b_in.i);
	assign chk_b_app = mul_rms(phase_b_in.v_rms, phase_b_in.i_rms);
	assign cfg_wr = ce && do_write && wword == CONFIG_OFS && wstrb_r[0];

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_react_signed: assert property ((ce && sample_valid && reactive_accum_mode != REACT_FOLLOW_ACTIVE) |=>
		phase_a_accum_in.reactive == $past(chk_a_react))
		else $error("reactive input not signed product");
	a_react_follow: assert property ((ce && sample_valid && reactive_accum_mode == REACT_FOLLOW_ACTIVE
		&& chk_a_act < 0) |=> phase_a_accum_in.reactive == prod_t'(-$past(chk_a_react)))
		else $error("reactive input not negated for negative active power");
	a_cfg_field: assert property (cfg_wr |=> wiring_config_select == wiring_e'($past(wdata_r[5:4])))
		else $error("wiring field not taken from write");
	a_phase_a_route: assert property ((ce && sample_valid) |=> phase_a_accum_in.active == $past(chk_a_act))
		else $error("phase A active input wrong");
	a_phase_c_route: assert property ((ce && sample_valid) |=> phase_c_accum_in.active == $past(chk_c_act))
		else $error("phase C active input wrong");
	a_b_delta_zero: assert property ((ce && sample_valid && wiring_config_select == WIRE_3W_DELTA) |=>
		phase_b_accum_in.active == 0 && phase_b_accum_in.reactive == 0 && phase_b_accum_in.apparent == 0)
		else $error("phase B not zero under delta");
	a_b_two_sensor: assert property ((ce && sample_valid && wiring_config_select == WIRE_4W_2V) |=>
		phase_b_accum_in.active == $past(chk_b_act2))
		else $error("phase B derived voltage wrong");
	a_b_apparent: assert property ((ce && sample_valid && wiring_config_select != WIRE_3W_DELTA) |=>
		phase_b_accum_in.apparent == $past(chk_b_app))
		else $error("phase B apparent input wrong");
	a_rev_active: assert property ((ce && ev_act[0]) |=> status_r[REV_ACT_BIT0])
		else $error("reverse active flag A not set");
	a_rev_reactive: assert property ((ce && ev_react[2]) |=> status_r[REV_REACT_BIT0 + 2])
		else $error("reverse reactive flag C not set");
	a_irq_level: assert property (irq == |(status_r & mask_r))
		else $error("interrupt level mismatch");

	c_follow_neg: cover property (ce && sample_valid && reactive_accum_mode == REACT_FOLLOW_ACTIVE && chk_a_act < 0);
	c_delta: cover property (ce && sample_valid && wiring_config_select == WIRE_3W_DELTA);
	c_irq_rise: cover property ($rose(irq));
	c_status_clear: cover property ($fell(status_r[REV_ACT_BIT0]));

endmodule

/* test/test_energy_accum_input_select.sv */
`timescale 1ns/10ps
module test_energy_accum_input_select import energy_pkg::*; ();
	// ****************************************
	// Signals
	// ****************************************
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b0;
	logic sample_valid = 1'b0;
	phase_in_s pin[3] = '{'0, '0, '0};
	addend_s acc[3];
	addend_s hold;
	logic accum_valid, irq, awready, wready, bvalid, arready, rvalid;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [3:0] wstrb = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, rd, r;
	logic [1:0] bresp, rresp, rsp;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'hF49D;
	logic [31:0] exp_status = 32'h0;
	logic [31:0] exp_mask = 32'h0;
	logic [7:0] cfg = 8'h0;
	logic [2:0] prev_a = 3'h0;
	logic [2:0] prev_r = 3'h0;

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

	always #2 aclk = ~aclk;

	energy_accum_input_select dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .sample_valid(sample_valid),
		.phase_a_in(pin[0]), .phase_b_in(pin[1]), .phase_c_in(pin[2]), .phase_a_accum_in(acc[0]),
		.phase_b_accum_in(acc[1]), .phase_c_accum_in(acc[2]), .accum_valid(accum_valid), .irq(irq),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic prod_t mul(logic signed [25:0] v, logic signed [23:0] i);
		return prod_t'(longint'(v) * longint'(i));
	endfunction

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One access; payload held until each channel is taken
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge aclk);
		if (wr) begin
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			awaddr <= a;
			wdata <= d;
			wstrb <= s;
			bready <= 1'b1;
		end else begin
			arvalid <= 1'b1;
			araddr <= a;
			rready <= 1'b1;
		end
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (wr && bready && bvalid === 1'b1) begin
				bready <= 1'b0;
				rsp = bresp;
				break;
			end
			if (!wr && rready && rvalid === 1'b1) begin
				rready <= 1'b0;
				rsp = rresp;
				rd = rdata;
				break;
			end
		end
		if (n == 50) begin
			error_cnt++;
			report_and_stop();
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
		`CHK(rsp, RESP_OKAY)
	endtask

	task rd_chk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'h0);
		`CHK(rsp, RESP_OKAY)
		`CHK(rd, e)
	endtask

	// Expected addends and flags worked out before the sample is driven
	task send(input logic corner);
		phase_in_s p[3];
		addend_s e[3];
		logic signed [25:0] v[3];
		logic signed [25:0] vf[3];
		logic na, nr;
		for (int k = 0; k < 3; k++) begin
			p[k] = corner ? {8{24'h800000}} : {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
			v[k] = p[k].v;
			vf[k] = p[k].v_fund;
		end
		if (cfg[5:4] == 2'h2) begin
			v[1] = -v[0] - v[2];
			vf[1] = -vf[0] - vf[2];
		end else if (cfg[5:4] == 2'h3) begin
			v[1] = -v[0];
			vf[1] = -vf[0];
		end
		for (int k = 0; k < 3; k++) begin
			e[k].active = mul(v[k], p[k].i);
			e[k].fund_active = mul(vf[k], p[k].i_fund);
			e[k].reactive = mul(v[k], p[k].i_shift);
			e[k].fund_reactive = mul(vf[k], p[k].i_fund_shift);
			e[k].apparent = prod_t'(longint'(p[k].v_rms) * longint'(p[k].i_rms));
			if (k == 1 && cfg[5:4] == 2'h1) e[k] = '0;
			na = cfg[6] ? e[k].fund_active[PROD_W-1] : e[k].active[PROD_W-1];
			nr = cfg[7] ? e[k].fund_reactive[PROD_W-1] : e[k].reactive[PROD_W-1];
			if (na != prev_a[k]) exp_status[6+k] = 1'b1;
			if (nr != prev_r[k]) exp_status[10+k] = 1'b1;
			prev_a[k] = na;
			prev_r[k] = nr;
			if (cfg[3:2] == 2'h2 && e[k].active[PROD_W-1]) e[k].reactive = -e[k].reactive;
			if (cfg[3:2] == 2'h2 && e[k].fund_active[PROD_W-1]) e[k].fund_reactive = -e[k].fund_reactive;
		end
		@(posedge aclk);
		sample_valid <= 1'b1;
		for (int k = 0; k < 3; k++) pin[k] <= p[k];
		@(posedge aclk);
		sample_valid <= 1'b0;
		#1;
		`CHK(accum_valid, 1'b1)
		`CHK(acc[0], e[0])
		`CHK(acc[1], e[1])
		`CHK(acc[2], e[2])
		`CHK(irq, |(exp_status & exp_mask))
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		ce <= 1'b1;
		rd_chk(CONFIG_OFS, 32'h0);
		rd_chk(STATUS_OFS, 32'h0);
		rd_chk(MASK_OFS, 32'h0);
		bus(1'b0, 4'hC, 32'h0, 4'h0);
		`CHK(rsp, RESP_SLVERR)
		`CHK(rd, 32'h0)
		bus(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
		`CHK(rsp, RESP_SLVERR)
		bus(1'b1, CONFIG_OFS, 32'hFF, 4'hE);
		`CHK(rsp, RESP_OKAY)
		rd_chk(CONFIG_OFS, 32'h0);
		$display("register checks done");
		for (int t = 0; t < 16; t++) begin
			r = rnd();
			cfg = {r[7:6], t[3:2], t[1:0], r[1:0]};
			wr(CONFIG_OFS, {r[31:8], cfg});
			rd_chk(CONFIG_OFS, {24'h0, cfg});
			r = rnd();
			exp_mask = r & STATUS_IMPL;
			wr(MASK_OFS, r);
			rd_chk(MASK_OFS, exp_mask);
			for (int j = 0; j < 6; j++) send(t == 5 && j == 0);
			rd_chk(STATUS_OFS, exp_status);
			r = rnd();
			wr(STATUS_OFS, r);
			exp_status = exp_status & ~r;
			rd_chk(STATUS_OFS, exp_status);
			`CHK(irq, |(exp_status & exp_mask))
			$display("config %0h done", cfg);
		end
		// Frozen clock enable must swallow a changed sample
		hold = acc[0];
		@(posedge aclk);
		ce <= 1'b0;
		sample_valid <= 1'b1;
		for (int k = 0; k < 3; k++) pin[k] <= ~pin[k];
		@(posedge aclk);
		ce <= 1'b1;
		sample_valid <= 1'b0;
		#1;
		`CHK(accum_valid, 1'b0)
		`CHK(acc[0], hold)
		$display("clock enable check done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(CONFIG_OFS, 32'h0);
		rd_chk(STATUS_OFS, 32'h0);
		rd_chk(MASK_OFS, 32'h0);
		`CHK(irq, 1'b0)
		`CHK(acc[0], '0)
		$display("second reset done");
		report_and_stop();
	end
endmodule
